/* File: hw/spg_top.sv */
// sine pattern generator: apb registers, step sequencer, converter drive
`timescale 1ns/1ns
`default_nettype none
module spg_top (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// converter and analog controls
	output logic      [9:0]           dac_code,
	output logic                      dac_power_on,
	output spg_pkg::spg_analog_t      analog_ctrl
);

	// ==================================================================
	// control registers
	logic [7:0] gen_ctrl_r,  gen_ctrl_nxt;
	logic [7:0] divider_r,   divider_nxt;
	logic [7:0] half_len_r,  half_len_nxt;
	logic [7:0] amp_ctrl_r,  amp_ctrl_nxt;
	logic [7:0] sw_low_r,    sw_low_nxt;
	logic [7:0] sw_high_r,   sw_high_nxt;

	// apb answer
	logic [31:0] prdata_r,  prdata_nxt;
	logic        pready_r,  pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        rd_pend_r, rd_pend_nxt;

	// sequencer
	spg_pkg::spg_state_t state_r, state_nxt;
	logic [5:0]  step_r, step_nxt;
	logic [9:0]  dac_r, dac_nxt;
	logic        dac_pw_r, dac_pw_nxt;
	logic        fetch_r, fetch_nxt;
	logic        hi_half_r, hi_half_nxt;
	logic        hi_half_d_r;
	spg_pkg::spg_analog_t ana_r, ana_nxt;

	// memory port
	logic       ram_we;
	logic [4:0] ram_addr;
	logic [8:0] ram_wdata;
	logic [8:0] ram_rdata;
	logic       step_en;

	// decoded helpers
	logic       gen_on;
	logic [5:0] half_steps;
	logic [6:0] full_steps;
	logic       acc_phase;
	logic       pat_hit;
	logic       pat_word;
	logic [4:0] pat_idx;
	logic       cpu_ram_we;

	// masked byte write honouring strobe lane 0
	function automatic logic [7:0] spg_wr8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [7:0] m);
		spg_wr8 = s[0] ? (d[7:0] & m) : old; // R13
	endfunction : spg_wr8

	assign gen_on     = gen_ctrl_r[spg_pkg::SPG_BIT_GEN_ON]; // R8
	assign half_steps = {1'b0, half_len_r[4:0]} + 6'h01; // R12
	assign full_steps = {half_steps, 1'b0};
	assign acc_phase  = psel && penable && !pready_r;
	assign pat_hit    = (paddr >= spg_pkg::SPG_OFS_PAT_BASE) && (paddr <= spg_pkg::SPG_OFS_PAT_LAST);
	// two words per entry: even word low byte, odd word bit 8
	assign pat_idx    = paddr[7:3]; // R4
	assign pat_word   = paddr[2];

	// ==================================================================
	// divider and pattern store
	spg_divider u_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (gen_on),
		.div_field (divider_r[5:0]), // R17
		.step_en   (step_en)
	);

	spg_pattern_ram u_ram (
		.pclk  (pclk),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (ram_wdata),
		.rdata (ram_rdata)
	);

	// cpu write of one byte half into the 9-bit entry; blocked while running
	assign cpu_ram_we = acc_phase && pwrite && pat_hit && !gen_on && pstrb[0]; // R5

	// memory port mux: generator owns the store while enabled
	always_comb begin
		ram_we    = 1'b0;
		ram_addr  = pat_idx;
		ram_wdata = 9'h000;
		if (gen_on) begin
			ram_addr = hi_half_r ? 5'(step_r - half_steps) : step_r[4:0]; // R19
		end else if (cpu_ram_we) begin
			ram_we    = 1'b1; // R4
			ram_wdata = pat_word ? {pwdata[0], ram_rdata[7:0]} : {ram_rdata[8], pwdata[7:0]};
		end
	end

	// ==================================================================
	// register bus: two-cycle access, pattern reads wait one more cycle
	always_comb begin
		gen_ctrl_nxt = gen_ctrl_r;
		divider_nxt  = divider_r;
		half_len_nxt = half_len_r;
		amp_ctrl_nxt = amp_ctrl_r;
		sw_low_nxt   = sw_low_r;
		sw_high_nxt  = sw_high_r;
		prdata_nxt   = prdata_r;
		pready_nxt   = 1'b0;
		pslverr_nxt  = 1'b0;
		rd_pend_nxt  = 1'b0;
		if (acc_phase && pat_hit && !pwrite && !gen_on && !rd_pend_r) begin
			// address was already on the memory port; wait for registered data
			rd_pend_nxt = 1'b1;
		end else if (acc_phase) begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0000_0000;
			if (pat_hit) begin
				if (gen_on) begin
					pslverr_nxt = 1'b1; // R5
				end else if (!pwrite) begin
					prdata_nxt = pat_word ? {31'h0, ram_rdata[8]} : {24'h0, ram_rdata[7:0]};
				end
			end else begin
				unique case (paddr)
					spg_pkg::SPG_OFS_GEN_CTRL: begin
						prdata_nxt = {24'h0, gen_ctrl_r};
						if (pwrite) gen_ctrl_nxt = spg_wr8(gen_ctrl_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_GEN_CTRL); // R9
					end
					spg_pkg::SPG_OFS_DIVIDER: begin
						prdata_nxt = {24'h0, divider_r};
						if (pwrite) divider_nxt = spg_wr8(divider_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_DIVIDER); // R11
					end
					spg_pkg::SPG_OFS_HALF_LEN: begin
						prdata_nxt = {24'h0, half_len_r};
						if (pwrite) half_len_nxt = spg_wr8(half_len_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_HALF_LEN); // R12
					end
					spg_pkg::SPG_OFS_AMP_CTRL: begin
						prdata_nxt = {24'h0, amp_ctrl_r};
						if (pwrite) amp_ctrl_nxt = spg_wr8(amp_ctrl_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_AMP_CTRL); // R14
					end
					spg_pkg::SPG_OFS_SW_LOW: begin
						prdata_nxt = {24'h0, sw_low_r};
						if (pwrite) sw_low_nxt = spg_wr8(sw_low_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_SW_LOW); // R16
					end
					spg_pkg::SPG_OFS_SW_HIGH: begin
						prdata_nxt = {24'h0, sw_high_r};
						if (pwrite) sw_high_nxt = spg_wr8(sw_high_r, pwdata, pstrb,
							spg_pkg::SPG_MASK_SW_HIGH); // R16
					end
					spg_pkg::SPG_OFS_STATUS: begin
						prdata_nxt = {16'h0, 2'b00, step_r, 7'h00, gen_on};
						pslverr_nxt = pwrite;
					end
					default: begin
						pslverr_nxt = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_ctrl_r <= spg_pkg::SPG_RST_CTRL; // R20
			divider_r  <= spg_pkg::SPG_RST_CTRL;
			half_len_r <= spg_pkg::SPG_RST_CTRL;
			amp_ctrl_r <= spg_pkg::SPG_RST_CTRL;
			sw_low_r   <= spg_pkg::SPG_RST_CTRL;
			sw_high_r  <= spg_pkg::SPG_RST_CTRL;
			prdata_r   <= 32'h0000_0000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			rd_pend_r  <= 1'b0;
		end else begin
			gen_ctrl_r <= gen_ctrl_nxt;
			divider_r  <= divider_nxt;
			half_len_r <= half_len_nxt;
			amp_ctrl_r <= amp_ctrl_nxt;
			sw_low_r   <= sw_low_nxt;
			sw_high_r  <= sw_high_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
			rd_pend_r  <= rd_pend_nxt;
		end
	end

	// ==================================================================
	// step sequencer: step count 0..full_steps-1, entry fetched then driven
	always_comb begin
		state_nxt   = state_r;
		step_nxt    = step_r;
		hi_half_nxt = hi_half_r;
		fetch_nxt   = 1'b0;
		dac_nxt     = dac_r;
		dac_pw_nxt  = gen_on; // R8
		unique case (state_r)
			spg_pkg::SPG_IDLE: begin
				step_nxt    = 6'h00;
				hi_half_nxt = 1'b0;
				dac_nxt     = 10'h000;
				if (gen_on) state_nxt = spg_pkg::SPG_RUN;
			end
			spg_pkg::SPG_RUN: begin
				if (!gen_on) begin
					state_nxt = spg_pkg::SPG_IDLE;
				end else if (step_en) begin
					fetch_nxt = 1'b1; // R6
					// 5-bit entry address, 6-bit count covers full cycles up to 64 steps
					if ({1'b0, step_r} + 7'h01 >= full_steps) begin
						step_nxt    = 6'h00; // R19
						hi_half_nxt = 1'b0;
					end else begin
						step_nxt    = step_r + 6'h01; // R18
						hi_half_nxt = (step_r + 6'h01) >= half_steps;
					end
				end
			end
			default: state_nxt = spg_pkg::SPG_IDLE;
		endcase
		// fetched entry arrives one clock after address; top bit marks half
		if (fetch_r) begin
			dac_nxt = {~hi_half_d_r, ram_rdata}; // R7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r     <= spg_pkg::SPG_IDLE;
			step_r      <= 6'h00;
			hi_half_r   <= 1'b0;
			hi_half_d_r <= 1'b0;
			fetch_r     <= 1'b0;
			dac_r       <= 10'h000;
			dac_pw_r    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			step_r      <= step_nxt;
			hi_half_r   <= hi_half_nxt;
			hi_half_d_r <= hi_half_r;
			fetch_r     <= fetch_nxt;
			dac_r       <= dac_nxt;
			dac_pw_r    <= dac_pw_nxt;
		end
	end

	// ==================================================================
	// analog control outputs registered from the control bits
	always_comb begin
		ana_nxt.wave_gen_on          = gen_on; // R8
		ana_nxt.bias_resistor_on     = gen_ctrl_r[spg_pkg::SPG_BIT_BIAS_ON]; // R10
		ana_nxt.amps_on              = amp_ctrl_r[spg_pkg::SPG_BIT_AMPS_ON]; // R14
		ana_nxt.second_amp_gain_code = (amp_ctrl_r[3:0] > spg_pkg::SPG_GAIN_MAX) ?
			4'h0 : amp_ctrl_r[3:0]; // R15
		ana_nxt.analog_switch_bits   = {sw_high_r[1:0], sw_low_r}; // R16
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana_r <= '0; // R20
		end else begin
			ana_r <= ana_nxt;
		end
	end

	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign dac_code     = dac_r;
	assign dac_power_on = dac_pw_r;
	assign analog_ctrl  = ana_r;

	// ==================================================================
	// checks
	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		(state_r == spg_pkg::SPG_RUN && gen_on) |-> ({1'b0, step_r} < full_steps);
	endproperty
	a_wrap: assert property (p_wrap) else $error("step count beyond full cycle"); // R19

	property p_half_flag;
		@(posedge pclk) disable iff (!presetn)
		(state_r == spg_pkg::SPG_RUN) |-> (hi_half_r == (step_r >= half_steps));
	endproperty
	a_half_flag: assert property (p_half_flag) else $error("half flag disagrees with count"); // R7

	property p_pwr_down;
		@(posedge pclk) disable iff (!presetn)
		!gen_on ##1 !gen_on |-> !dac_power_on && !analog_ctrl.wave_gen_on;
	endproperty
	a_pwr_down: assert property (p_pwr_down) else $error("converter powered while off"); // R8

	property p_block;
		@(posedge pclk) disable iff (!presetn)
		(acc_phase && pat_hit && gen_on) |=> pready && pslverr;
	endproperty
	a_block: assert property (p_block) else $error("pattern access not blocked"); // R5

	property p_no_we;
		@(posedge pclk) disable iff (!presetn)
		gen_on |-> !ram_we;
	endproperty
	a_no_we: assert property (p_no_we) else $error("pattern write while running"); // R5

	property p_gain;
		@(posedge pclk) disable iff (!presetn)
		(amp_ctrl_r[3:0] > 4'hA) |=> analog_ctrl.second_amp_gain_code == 4'h0;
	endproperty
	a_gain: assert property (p_gain) else $error("illegal gain code not unity"); // R15

	property p_switch;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> analog_ctrl.analog_switch_bits == $past({sw_high_r[1:0], sw_low_r});
	endproperty
	a_switch: assert property (p_switch) else $error("switch outputs mismatch"); // R16

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		(divider_r[7:6] == 2'b00) && (half_len_r[7:5] == 3'b000) && (gen_ctrl_r[3:0] == 4'h0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("unimplemented bit set"); // R13

	// a running step is fetched at the next edge and reaches the converter one after
	sequence s_step_taken;
		(state_r == spg_pkg::SPG_RUN) && gen_on && step_en;
	endsequence
	sequence s_fetch_seen;
		fetch_r ##1 (dac_r[8:0] == $past(ram_rdata));
	endsequence
	property p_fetch;
		@(posedge pclk) disable iff (!presetn)
		s_step_taken |=> s_fetch_seen;
	endproperty
	a_fetch: assert property (p_fetch) else $error("step not fetched to converter"); // R6

endmodule : spg_top
`default_nettype wire

/* File: pkg/spg_pkg.sv */
// package with register map, field layout and types for the sine pattern generator
// Function
// R1 - pattern counter steps at system clock divided by N; a period spans M clocks
// R2 - software picks M a multiple of N and 8; M/N full steps, twice half, <=64
// R3 - pattern store holds 32 entries of 9 bits; half cycle at most 32
// R4 - entry low byte at even address, bit 8 at next odd address, 00h-3Fh
// R5 - while generator runs, processor pattern memory reads and writes are blocked
// R6 - each step fetches the addressed entry and drives it to the converter
// R7 - converter bit 9 is high while step count below half steps, else low
// R8 - generator enable bit 7 runs generator; when 0, output amp and converter power down
// R9 - software writes zeros to reserved control bits 6 and 5
// R10 - bias bit 4 enables bias resistors when 1, powers them down when 0
// R11 - divider ratio N equals 6-bit divider field plus one
// R12 - half cycle steps equal 5-bit length field plus one
// R13 - unimplemented control bits read zero and ignore writes
// R14 - amplifier enable bit 7 powers both measurement amps; 0 powers them down
// R15 - 4-bit gain code picks second amp gain; codes above 1010 give unity
// R16 - ten switch bits close switches when 1; 0-7 low register, 8-9 high register
// R17 - divider and length settings cover sine frequencies 5 kHz to 500 kHz
// R18 - a 5-bit counter addresses the stored pattern entries; the code counts steps in 6 bits and derives the 5-bit address
// R19 - step count runs 0 to full steps minus one, addressing count then count minus half
// R20 - all control bits clear at reset; everything disabled, switches open
package spg_pkg;

	// ==================================================================
	// register byte addresses (32-bit aligned words)
	localparam logic [11:0] SPG_OFS_GEN_CTRL   = 12'h000;
	localparam logic [11:0] SPG_OFS_DIVIDER    = 12'h004;
	localparam logic [11:0] SPG_OFS_HALF_LEN   = 12'h008;
	localparam logic [11:0] SPG_OFS_AMP_CTRL   = 12'h00C;
	localparam logic [11:0] SPG_OFS_SW_LOW     = 12'h010;
	localparam logic [11:0] SPG_OFS_SW_HIGH    = 12'h014;
	localparam logic [11:0] SPG_OFS_STATUS     = 12'h018;
	localparam logic [11:0] SPG_OFS_PAT_BASE   = 12'h100;
	localparam logic [11:0] SPG_OFS_PAT_LAST   = 12'h1FC;

	// ==================================================================
	// writable bit masks of each control register
	localparam logic [7:0] SPG_MASK_GEN_CTRL  = 8'hF0;
	localparam logic [7:0] SPG_MASK_DIVIDER   = 8'h3F;
	localparam logic [7:0] SPG_MASK_HALF_LEN  = 8'h1F;
	localparam logic [7:0] SPG_MASK_AMP_CTRL  = 8'h8F;
	localparam logic [7:0] SPG_MASK_SW_LOW    = 8'hFF;
	localparam logic [7:0] SPG_MASK_SW_HIGH   = 8'h03;
	localparam logic [7:0] SPG_RST_CTRL       = 8'h00;

	// field positions
	localparam int SPG_BIT_GEN_ON  = 7;
	localparam int SPG_BIT_BIAS_ON = 4;
	localparam int SPG_BIT_AMPS_ON = 7;

	// ==================================================================
	// pattern store geometry
	localparam int SPG_PAT_DEPTH = 32;
	localparam int SPG_PAT_AW    = 5;
	localparam int SPG_PAT_DW    = 9;
	localparam logic [3:0] SPG_GAIN_MAX = 4'hA;

	// control outputs to the analog section
	typedef struct packed {
		logic       wave_gen_on;
		logic       bias_resistor_on;
		logic       amps_on;
		logic [3:0] second_amp_gain_code;
		logic [9:0] analog_switch_bits;
	} spg_analog_t;

	// state of the step sequencer
	typedef enum logic [1:0] {
		SPG_IDLE = 2'b01,
		SPG_RUN  = 2'b10
	} spg_state_t;

endpackage : spg_pkg

/* File: hw/spg_divider.sv */
// clock divider giving one step enable every N system clocks
`timescale 1ns/1ns
`default_nettype none
module spg_divider (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       run,
	input  wire logic [5:0] div_field,
	// step enable pulse
	output logic            step_en
);

	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic       step_r;
	logic       step_nxt;

	// count 0..div_field, pulse on the last count so period is field+1
	always_comb begin
		cnt_nxt  = cnt_r;
		step_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = 6'h00;
		end else if (cnt_r >= div_field) begin
			cnt_nxt  = 6'h00; // R11
			step_nxt = 1'b1; // R1
		end else begin
			cnt_nxt = cnt_r + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= 6'h00;
			step_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			step_r <= step_nxt;
		end
	end

	assign step_en = step_r;

	// a step pulse is followed by at least one quiet cycle while running with a stable nonzero div_field
	property p_div_gap;
		@(posedge pclk) disable iff (!presetn)
		(step_r && run && $stable(div_field) && div_field != 6'h00) |=> !step_r;
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("step pulses too close"); // R1

	property p_div_one;
		@(posedge pclk) disable iff (!presetn)
		(run && div_field == 6'h00 && $past(run) && $past(div_field) == 6'h00 && $past(run, 2))
			|-> step_r;
	endproperty
	a_div_one: assert property (p_div_one) else $error("ratio one must step each clock"); // R11

endmodule : spg_divider
`default_nettype wire

/* File: hw/spg_pattern_ram.sv */
// 32 x 9 pattern store with one read/write port
`timescale 1ns/1ns
`default_nettype none
module spg_pattern_ram (
	// clock
	input  wire logic       pclk,
	// port
	input  wire logic       we,
	input  wire logic [4:0] addr,
	input  wire logic [8:0] wdata,
	output logic      [8:0] rdata
);

	logic [8:0] mem [0:31]; // R3
	logic [8:0] rd_r;

	// synchronous write and registered read
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rd_r <= mem[addr];
	end

	assign rdata = rd_r;

endmodule : spg_pattern_ram
`default_nettype wire

/* File: test/spg_dac_model.sv */
// behavioural model of the 10-bit converter and smoothing filter fed by the generator
`timescale 1ns/1ns
`default_nettype none
module spg_dac_model (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// converter input
	input  wire logic [9:0]         dac_code,
	input  wire logic               dac_power_on,
	// analog view
	output logic signed [10:0]      level,
	output logic signed [10:0]      smooth
);
	// ==================================================================
	// converter: mid-scale offset removed, bit 9 picks the half cycle
	always_comb begin
		if (dac_power_on) begin
			level = $signed({1'b0, dac_code}) - 11'sd512;
		end else begin
			level = 11'sd0;
		end
	end

	// one-pole smoothing, so fast settings lose amplitude as the real filter does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smooth <= 11'sd0;
		end else begin
			smooth <= smooth + ((level - smooth) >>> 2);
		end
	end
endmodule : spg_dac_model
`default_nettype wire

/* File: test/test_sine_pattern_generator.sv */
// self-checking testbench of the sine pattern generator
`timescale 1ns/1ns
`default_nettype none
module test_sine_pattern_generator;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, dac_power_on;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata;
	logic [3:0]           pstrb;
	logic [9:0]           dac_code;
	spg_pkg::spg_analog_t analog_ctrl;
	logic signed [10:0]   dac_level;
	int                   n_errors, total_checks, cycles;
	logic [11:0]          addrs [6] = '{spg_pkg::SPG_OFS_GEN_CTRL, spg_pkg::SPG_OFS_DIVIDER,
		spg_pkg::SPG_OFS_HALF_LEN, spg_pkg::SPG_OFS_AMP_CTRL, spg_pkg::SPG_OFS_SW_LOW,
		spg_pkg::SPG_OFS_SW_HIGH};
	logic [7:0]           masks [6] = '{spg_pkg::SPG_MASK_GEN_CTRL, spg_pkg::SPG_MASK_DIVIDER,
		spg_pkg::SPG_MASK_HALF_LEN, spg_pkg::SPG_MASK_AMP_CTRL, spg_pkg::SPG_MASK_SW_LOW,
		spg_pkg::SPG_MASK_SW_HIGH};

	spg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dac_code(dac_code),
		.dac_power_on(dac_power_on), .analog_ctrl(analog_ctrl));

	spg_dac_model dac (.pclk(pclk), .presetn(presetn), .dac_code(dac_code),
		.dac_power_on(dac_power_on), .level(dac_level), .smooth());

	// ==================================================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			$display("mismatch timeout expected end seen hang");
			end_of_test();
		end
	end

	// ==================================================================
	// compare, bus and closing tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one transfer: setup, access held until pready is seen at an edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		check("pready", 32'h1, 32'(pready));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, {24'h0, d}, r, e);
		check("write error flag", 32'(ee), 32'(e));
	endtask : wr

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		check(nm, exp, r);
		check("read error flag", 32'(ee), 32'(e));
	endtask : rdc

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// ==================================================================
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 6; i++) rdc("reset value", addrs[i], 32'h0, 1'b0);
		check("analog controls at reset", 32'h0, {15'h0, analog_ctrl});
		check("converter power at reset", 32'h0, 32'(dac_power_on));
	endtask : t_reset

	task automatic t_masks;
		logic [7:0] d;
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h1F : 8'hFF;
			wr(addrs[i], d, 1'b0);
			rdc("register mask", addrs[i], {24'h0, masks[i] & d}, 1'b0);
		end
		repeat (2) @(posedge pclk);
		check("bias on", 32'h1, 32'(analog_ctrl.bias_resistor_on));
		check("amps on", 32'h1, 32'(analog_ctrl.amps_on));
		check("switches closed", 32'h3FF, 32'(analog_ctrl.analog_switch_bits));
		for (int i = 0; i < 6; i++) wr(addrs[i], 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		check("controls cleared", 32'h0, {15'h0, analog_ctrl});
		for (int c = 0; c < 16; c++) begin
			wr(spg_pkg::SPG_OFS_AMP_CTRL, 8'(c), 1'b0);
			repeat (2) @(posedge pclk);
			check("gain code", (c <= 10) ? 32'(c) : 32'h0, 32'(analog_ctrl.second_amp_gain_code));
		end
		wr(spg_pkg::SPG_OFS_STATUS, 8'h01, 1'b1);
		wr(12'h020, 8'h01, 1'b1);
	endtask : t_masks

	task automatic t_wave;
		logic [9:0] exp [8];
		logic [8:0] p;
		logic [9:0] prev;
		int         n;
		for (int k = 0; k < 4; k++) begin
			p = 9'(9'h0A5 + k * 71);
			wr(spg_pkg::SPG_OFS_PAT_BASE + 12'(8 * k), p[7:0], 1'b0);
			wr(spg_pkg::SPG_OFS_PAT_BASE + 12'(8 * k + 4), {7'h0, p[8]}, 1'b0);
			exp[k] = {1'b1, p};
			exp[k + 4] = {1'b0, p};
		end
		rdc("pattern low byte", spg_pkg::SPG_OFS_PAT_BASE + 12'h008, 32'h0EC, 1'b0);
		wr(spg_pkg::SPG_OFS_PAT_LAST, 8'h01, 1'b0);
		rdc("last entry high bit", spg_pkg::SPG_OFS_PAT_LAST, 32'h1, 1'b0);
		wr(spg_pkg::SPG_OFS_DIVIDER, 8'h01, 1'b0);
		wr(spg_pkg::SPG_OFS_HALF_LEN, 8'h03, 1'b0);
		wr(spg_pkg::SPG_OFS_GEN_CTRL, 8'h90, 1'b0);
		repeat (2) @(posedge pclk);
		check("converter power", 32'h1, 32'(dac_power_on));
		check("generator on", 32'h1, 32'(analog_ctrl.wave_gen_on));
		rdc("pattern read while running", spg_pkg::SPG_OFS_PAT_BASE, 32'h0, 1'b1);
		wr(spg_pkg::SPG_OFS_PAT_BASE, 8'h00, 1'b1);
		n = 0;
		prev = dac_code;
		do begin
			prev = dac_code;
			@(posedge pclk);
			n++;
		end while (!(dac_code === exp[0] && prev !== exp[0]) && n < 200);
		check("first step code", 32'(exp[0]), 32'(dac_code));
		for (int i = 1; i <= 16; i++) begin
			prev = dac_code;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (dac_code === prev && n < 20);
			check("step spacing", 32'h2, 32'(n));
			check("converter code", 32'(exp[i % 8]), 32'(dac_code));
			check("level half", 32'(exp[i % 8][9]), 32'(!dac_level[10]));
		end
		wr(spg_pkg::SPG_OFS_GEN_CTRL, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		check("converter power off", 32'h0, 32'(dac_power_on));
		rdc("pattern read when stopped", spg_pkg::SPG_OFS_PAT_BASE, 32'h0A5, 1'b0);
		rdc("status when stopped", spg_pkg::SPG_OFS_STATUS, 32'h0, 1'b0);
	endtask : t_wave

	// ==================================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		n_errors = 0;
		total_checks = 0;
		cycles = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_masks();
		t_wave();
		end_of_test();
	end
endmodule : test_sine_pattern_generator
`default_nettype wire
